//--- design/press_contact_defines.vh
// constants of the press contact monitor
`ifndef PRESS_CONTACT_DEFINES_VH
`define PRESS_CONTACT_DEFINES_VH
// clock rate in cycles per millisecond (100 MHz)
`define CYC_PER_MS        32'h0001_86A0
// rearm pulse limits, in their own units
`define REARM_MIN_SHORT_MS 32'h0000_0064
`define REARM_MIN_LONG_MS  32'h0000_015E
`define REARM_MAX_S        32'h0000_001E
`define MS_PER_S           32'h0000_03E8
// input vector positions
`define IN_W      6
`define IN_TOP    0
`define IN_LOW    1
`define IN_OVR    2
`define IN_DRV    3
`define IN_SHAFT  4
`define IN_REARM  5
// synchroniser settle time before monitoring starts
`define SETTLE_W   3
`define SETTLE_CYC 3'h4
// register map (byte addresses)
`define ADDR_W     4
`define ADDR_CFG   4'h0
`define ADDR_STAT  4'h4
// config fields
`define CFG_W        5
`define CFG_REARM_EN 0
`define CFG_MODE02   1
`define CFG_MIN_LONG 2
`define CFG_ERRF_EN  3
`define CFG_OVR_EN   4
`define CFG_RESET    5'h1F
// status fields
`define ST_RELEASE 0
`define ST_TOP     1
`define ST_UP      2
`define ST_PEND    3
`define ST_SEQ     4
`define ST_OVR     5
`define ST_W       6
// lower-zone pulse counter
`define LCNT_W 2
`define LCNT_0 2'h0
`define LCNT_1 2'h1
`define LCNT_2 2'h2
`endif

//--- design/press_contact_monitor.v
// press cam contact sequence monitor with run permit and rearm
`timescale 1ns/1ps
`default_nettype none
`include "press_contact_defines.vh"
// Notes on behaviour
// - in one-pulse mode exactly one lower-zone pulse per press cycle, otherwise sequence fault
// - lower switch high at start keeps upstroke low during first press cycle
// - in 0-2 mode a second lower rise does not restart upstroke
// - in 0-2 mode no lower pulse keeps upstroke low all cycle
// - lower high at monitor start: next lower rise only after top flag fell
// - at overrun switch fall, drive must have risen after top or be high
// - shaft-ok low without fault: permit low, monitoring paused, faults kept
// - shaft-ok rise re-enters state implied by present switches
// - shaft-ok fall drops permit, top and upstroke flags, faults untouched
// - permit high when no fault and shaft-ok high
// - sequence fault drops permit, raises fault and rearm-pending
// - top flag high while top switch low, low on fault or shaft-ok low
// - upstroke set on lower rise, cleared by first top or lower fall, fault
// - rearm-pending held until valid rearm, permit never high meanwhile
// - every invalid top/lower switch sequence raises sequence fault, except while shaft-ok is low or a fault is latched
// - optional combined fault flag is high on either latched fault
// - valid rearm is high pulse between 100/350 ms and 30 s
// - one-pulse mode demands exactly one lower rise, while top switch high
// - lower switch still high at top switch rise is a sequence fault
// - with rearm disabled, faults clear only by restart (reset)
module press_contact_monitor #(
  parameter [31:0] REARM_MIN_SHORT_CYC = `REARM_MIN_SHORT_MS * `CYC_PER_MS,
  parameter [31:0] REARM_MIN_LONG_CYC  = `REARM_MIN_LONG_MS * `CYC_PER_MS,
  parameter [31:0] REARM_MAX_CYC       = `REARM_MAX_S * `MS_PER_S * `CYC_PER_MS
) (
  input  wire                clk_sys_in,
  input  wire                rstn_in,
  input  wire                top_zone_switch_in,
  input  wire                lower_zone_switch_in,
  input  wire                overrun_switch_in,
  input  wire                drive_cmd_in,
  input  wire                shaft_ok_in,
  input  wire                rearm_in,
  input  wire [`ADDR_W-1:0]  addr_in,
  input  wire [31:0]         wdata_in,
  input  wire                wr_in,
  input  wire                rd_in,
  output reg  [31:0]         rdata_out,
  output wire                run_permit_out,
  output wire                top_flag_out,
  output wire                upstroke_out,
  output wire                rearm_pending_out,
  output wire                seq_fault_out,
  output wire                overrun_fault_out,
  output wire                fault_flag_out
);

  function edge_of;
    input cur;
    input prv;
    input rising;
    begin
      edge_of = rising ? (cur & ~prv) : (~cur & prv);
    end
  endfunction

  wire [`IN_W-1:0] raw = {rearm_in, shaft_ok_in, drive_cmd_in,
                          overrun_switch_in, lower_zone_switch_in, top_zone_switch_in};
  reg  [`IN_W-1:0] s1_r;
  reg  [`IN_W-1:0] s2_r;
  reg  [`IN_W-1:0] s3_r;
  reg  [`IN_W-1:0] filt_r;
  reg  [`IN_W-1:0] prev_r;

  // three-stage synchroniser, change taken once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `IN_W; gi = gi + 1)
    begin : g_sync
      always @(posedge clk_sys_in)
      begin
        if (!rstn_in)
        begin
          s1_r[gi]   <= 1'b0;
          s2_r[gi]   <= 1'b0;
          s3_r[gi]   <= 1'b0;
          filt_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi])
            filt_r[gi] <= s3_r[gi];
          prev_r[gi] <= filt_r[gi];
        end
      end
    end
  endgenerate

  wire top_sw = filt_r[`IN_TOP];
  wire low_sw = filt_r[`IN_LOW];
  wire drv    = filt_r[`IN_DRV];
  wire shaft  = filt_r[`IN_SHAFT];
  wire rearm  = filt_r[`IN_REARM];

  wire top_rise   = edge_of(top_sw, prev_r[`IN_TOP], 1'b1);
  wire top_fall   = edge_of(top_sw, prev_r[`IN_TOP], 1'b0);
  wire low_rise   = edge_of(low_sw, prev_r[`IN_LOW], 1'b1);
  wire low_fall   = edge_of(low_sw, prev_r[`IN_LOW], 1'b0);
  wire ovr_fall   = edge_of(filt_r[`IN_OVR], prev_r[`IN_OVR], 1'b0);
  wire drv_rise   = edge_of(drv, prev_r[`IN_DRV], 1'b1);
  wire shaft_rise = edge_of(shaft, prev_r[`IN_SHAFT], 1'b1);
  wire rearm_fall = edge_of(rearm, prev_r[`IN_REARM], 1'b0);

  reg [`CFG_W-1:0]    cfg_r;
  reg [`SETTLE_W-1:0] settle_r;
  reg                 run_r;
  reg                 start_r;
  reg                 top_r;
  reg                 up_r;
  reg                 up_done_r;
  reg                 armed_r;
  reg                 drive_seen_r;
  reg                 seq_r;
  reg                 ovr_r;
  reg                 pend_r;
  reg                 permit_r;
  reg                 errf_r;
  reg [`LCNT_W-1:0]   lcnt_r;
  reg [31:0]          rcnt_r;

  reg                 top_nxt;
  reg                 up_nxt;
  reg                 up_done_nxt;
  reg                 armed_nxt;
  reg                 drive_seen_nxt;
  reg                 seq_nxt;
  reg                 ovr_nxt;
  reg                 pend_nxt;
  reg                 seq_err;
  reg                 ovr_err;
  reg [`LCNT_W-1:0]   lcnt_nxt;

  wire mode02   = cfg_r[`CFG_MODE02];
  wire [31:0] rearm_min = cfg_r[`CFG_MIN_LONG] ? REARM_MIN_LONG_CYC : REARM_MIN_SHORT_CYC;
  wire rearm_ok = cfg_r[`CFG_REARM_EN] & rearm_fall & (rcnt_r >= rearm_min) &
                  (rcnt_r <= REARM_MAX_CYC);
  wire faulted  = seq_r | ovr_r;
  wire active   = run_r & shaft & ~faulted;

  always @*
  begin
    top_nxt        = 1'b0;
    up_nxt         = 1'b0;
    up_done_nxt    = up_done_r;
    armed_nxt      = armed_r;
    drive_seen_nxt = drive_seen_r;
    lcnt_nxt       = lcnt_r;
    seq_err        = 1'b0;
    ovr_err        = 1'b0;
    if (active && (start_r || shaft_rise))
    begin
      // enter state implied by present switches
      top_nxt        = ~top_sw;
      up_nxt         = 1'b0;
      up_done_nxt    = 1'b0;
      armed_nxt      = ~low_sw;
      drive_seen_nxt = 1'b0;
      // lower already high: this cycle's lower pulse is under way
      lcnt_nxt       = low_sw ? `LCNT_1 : `LCNT_0;
    end
    else if (active)
    begin
      top_nxt = ~top_sw;
      up_nxt  = up_r;
      if (top_rise)
      begin
        // top flag falls: new press cycle begins
        if (low_sw)
          seq_err = 1'b1;
        armed_nxt   = 1'b1;
        up_done_nxt = 1'b0;
        lcnt_nxt    = `LCNT_0;
      end
      if (top_fall)
      begin
        // press back in top zone: end of cycle
        if (!mode02 && lcnt_r != `LCNT_1 && !low_rise)
          seq_err = 1'b1;
        drive_seen_nxt = 1'b0;
        up_nxt         = 1'b0;
      end
      if (low_rise)
      begin
        if (!top_sw)
          seq_err = 1'b1;
        if (!mode02 && lcnt_r != `LCNT_0)
          seq_err = 1'b1;
        if (mode02 && lcnt_r == `LCNT_2)
          seq_err = 1'b1;
        if (lcnt_r != `LCNT_2)
          lcnt_nxt = lcnt_r + `LCNT_1;
        if (armed_r && !up_done_r)
          up_nxt = 1'b1;
        up_done_nxt = 1'b1;
      end
      if (low_fall)
        up_nxt = 1'b0;
      // cleared when the top flag rises, so any later drive rise counts
      if (drv_rise)
        drive_seen_nxt = 1'b1;
      if (cfg_r[`CFG_OVR_EN] && ovr_fall && !(drive_seen_r || drv))
        ovr_err = 1'b1;
      if (seq_err || ovr_err)
      begin
        top_nxt = 1'b0;
        up_nxt  = 1'b0;
      end
    end
    // faults latch; a valid rearm clears them
    seq_nxt  = (seq_r & ~rearm_ok) | seq_err;
    ovr_nxt  = (ovr_r & ~rearm_ok) | ovr_err;
    pend_nxt = (pend_r & ~rearm_ok) | seq_err | ovr_err;
  end

  always @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      settle_r     <= {`SETTLE_W{1'b0}};
      run_r        <= 1'b0;
      start_r      <= 1'b0;
      top_r        <= 1'b0;
      up_r         <= 1'b0;
      up_done_r    <= 1'b0;
      armed_r      <= 1'b0;
      drive_seen_r <= 1'b0;
      seq_r        <= 1'b0;
      ovr_r        <= 1'b0;
      pend_r       <= 1'b0;
      permit_r     <= 1'b0;
      errf_r       <= 1'b0;
      lcnt_r       <= `LCNT_0;
      rcnt_r       <= 32'h0000_0000;
    end
    else
    begin
      if (settle_r != `SETTLE_CYC)
        settle_r <= settle_r + 3'h1;
      run_r        <= (settle_r == `SETTLE_CYC);
      start_r      <= (run_r == 1'b0 && settle_r == `SETTLE_CYC) | rearm_ok;
      top_r        <= top_nxt;
      up_r         <= up_nxt;
      up_done_r    <= up_done_nxt;
      armed_r      <= armed_nxt;
      drive_seen_r <= drive_seen_nxt;
      lcnt_r       <= lcnt_nxt;
      seq_r        <= seq_nxt;
      ovr_r        <= ovr_nxt;
      pend_r       <= pend_nxt;
      permit_r     <= run_r & shaft & ~seq_nxt & ~ovr_nxt & ~pend_nxt;
      errf_r       <= cfg_r[`CFG_ERRF_EN] & (seq_nxt | ovr_nxt);
      // rearm high time, saturating just above the upper limit
      if (!rearm)
        rcnt_r <= 32'h0000_0000;
      else if (rcnt_r <= REARM_MAX_CYC)
        rcnt_r <= rcnt_r + 32'h0000_0001;
    end
  end

  // register port
  wire [`ST_W-1:0] status = {ovr_r, seq_r, pend_r, up_r, top_r, permit_r};

  always @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      cfg_r     <= `CFG_RESET;
      rdata_out <= 32'h0000_0000;
    end
    else
    begin
      if (wr_in && addr_in == `ADDR_CFG)
        cfg_r <= wdata_in[`CFG_W-1:0];
      if (rd_in && addr_in == `ADDR_CFG)
        rdata_out <= {{(32-`CFG_W){1'b0}}, cfg_r};
      else if (rd_in && addr_in == `ADDR_STAT)
        rdata_out <= {{(32-`ST_W){1'b0}}, status};
      else
        rdata_out <= 32'h0000_0000;
    end
  end

  assign run_permit_out    = permit_r;
  assign top_flag_out      = top_r;
  assign upstroke_out      = up_r;
  assign rearm_pending_out = pend_r;
  assign seq_fault_out     = seq_r;
  assign overrun_fault_out = ovr_r;
  assign fault_flag_out    = errf_r;

endmodule
`default_nettype wire

//--- testbench/press_cam_model.sv
// cam contacts and rearm button facing the press contact monitor
`timescale 1ns/1ps
`default_nettype none
module press_cam_model (
  input  wire logic clk_sys_in,
  output logic      top_sw_out = 1'b0,
  output logic      low_sw_out = 1'b0,
  output logic      ovr_sw_out = 1'b1,
  output logic      rearm_out  = 1'b0
);
  // move the contacts, then let them settle
  task automatic sw(input logic t, input logic l, input logic o);
    @(posedge clk_sys_in);
    top_sw_out <= t;
    low_sw_out <= l;
    ovr_sw_out <= o;
    repeat (8) @(posedge clk_sys_in);
  endtask
  // low-high-low pulse of len cycles
  task automatic rearm(input int len);
    @(posedge clk_sys_in);
    rearm_out <= 1'b1;
    repeat (len) @(posedge clk_sys_in);
    rearm_out <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

//--- testbench/press_contact_properties.sv
// checker for the press contact monitor
`timescale 1ns/1ps
`default_nettype none
module press_contact_properties (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic top_zone_switch_in,
  input wire logic lower_zone_switch_in,
  input wire logic overrun_switch_in,
  input wire logic drive_cmd_in,
  input wire logic shaft_ok_in,
  input wire logic run_permit_out,
  input wire logic top_flag_out,
  input wire logic upstroke_out,
  input wire logic rearm_pending_out,
  input wire logic seq_fault_out,
  input wire logic overrun_fault_out,
  input wire logic fault_flag_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  sequence shaft_gone;
    !shaft_ok_in [*7];
  endsequence
  pend_block_a: assert property (rearm_pending_out |-> !run_permit_out)
    else $error("permit while pending");
  shaft_off_a: assert property (shaft_gone |-> !run_permit_out && !top_flag_out)
    else $error("flags with shaft down");
  seq_trip_a: assert property ($rose(seq_fault_out) |-> rearm_pending_out)
    else $error("fault without pending");
  flag_cause_a: assert property (fault_flag_out |-> seq_fault_out || overrun_fault_out)
    else $error("fault flag without fault");
  up_rise_a: assert property ($rose(upstroke_out) |-> $past(lower_zone_switch_in, 2))
    else $error("upstroke without lower");
  up_fall_a: assert property ($fell(upstroke_out) |->
      !$past(lower_zone_switch_in, 2) || !$past(top_zone_switch_in, 2)
      || !$past(shaft_ok_in, 2) || seq_fault_out || overrun_fault_out)
    else $error("upstroke dropped early");
  top_rise_a: assert property ($rose(top_flag_out) |-> !$past(top_zone_switch_in, 2))
    else $error("top flag with top open");
  ovr_trip_a: assert property ($rose(overrun_fault_out) |->
      !$past(overrun_switch_in, 2) && !$past(drive_cmd_in, 2))
    else $error("overrun fault unfounded");
  permit_up_a: assert property ($rose(run_permit_out) |-> $past(shaft_ok_in, 2))
    else $error("permit without shaft");
endmodule
bind press_contact_monitor press_contact_properties chk_u (
  .clk_sys_in, .rstn_in, .top_zone_switch_in, .lower_zone_switch_in, .overrun_switch_in,
  .drive_cmd_in, .shaft_ok_in, .run_permit_out, .top_flag_out, .upstroke_out,
  .rearm_pending_out, .seq_fault_out, .overrun_fault_out, .fault_flag_out);
`default_nettype wire

//--- testbench/tb_top.sv
// bench of the press contact monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in;
  logic        drv;
  logic        shaft;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  int          fail_count = 0;
  int          check_count = 0;
  wire         t_sw, l_sw, o_sw, r_sw;
  wire [31:0]  rdata;
  wire [6:0]   st;
  always #5 clk_sys_in = ~clk_sys_in;
  press_cam_model cam_u (.clk_sys_in(clk_sys_in), .top_sw_out(t_sw), .low_sw_out(l_sw),
    .ovr_sw_out(o_sw), .rearm_out(r_sw));
  press_contact_monitor #(.REARM_MIN_SHORT_CYC(32'h0000_0014),
    .REARM_MIN_LONG_CYC(32'h0000_0028), .REARM_MAX_CYC(32'h0000_0064)) dut_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .top_zone_switch_in(t_sw),
    .lower_zone_switch_in(l_sw), .overrun_switch_in(o_sw), .drive_cmd_in(drv),
    .shaft_ok_in(shaft), .rearm_in(r_sw), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .run_permit_out(st[0]), .top_flag_out(st[1]),
    .upstroke_out(st[2]), .rearm_pending_out(st[3]), .seq_fault_out(st[4]),
    .overrun_fault_out(st[5]), .fault_flag_out(st[6]));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one write, or one read judged against e
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= e;
    wr <= w;
    rd <= !w;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 if (!w) cmp(rdata, e);
  endtask
  task automatic see(input logic [6:0] e);
    repeat (6) @(posedge clk_sys_in);
    #1 cmp(st, e);
  endtask
  task automatic t_start;
    see(7'h03);
    bus(1'b1, 4'h4, 32'h0000_003F);
    bus(1'b0, 4'h4, 32'h0000_0003);
    bus(1'b0, 4'h0, 32'h0000_001F);
    bus(1'b0, 4'h8, 32'h0000_0000);
    $display("test start done");
  endtask
  task automatic t_cycle;
    @(posedge clk_sys_in);
    drv <= 1'b1;
    cam_u.sw(1, 0, 1);
    see(7'h01);
    cam_u.sw(1, 0, 0);
    cam_u.sw(1, 1, 1);
    see(7'h05);
    cam_u.sw(1, 0, 1);
    see(7'h01);
    cam_u.sw(1, 1, 1);
    see(7'h01);
    cam_u.sw(0, 0, 1);
    see(7'h03);
    $display("test cycle done");
  endtask
  task automatic t_seq;
    bus(1'b1, 4'h0, 32'h0000_0019);
    cam_u.sw(1, 0, 1);
    cam_u.sw(0, 0, 1);
    see(7'h58);
    cam_u.rearm(10);
    see(7'h58);
    cam_u.rearm(30);
    see(7'h03);
    $display("test sequence done");
  endtask
  task automatic t_ovr;
    @(posedge clk_sys_in);
    drv <= 1'b0;
    bus(1'b1, 4'h0, 32'h0000_0017);
    cam_u.sw(1, 0, 0);
    see(7'h28);
    cam_u.rearm(120);
    see(7'h28);
    cam_u.rearm(60);
    see(7'h01);
    cam_u.sw(0, 0, 1);
    see(7'h03);
    $display("test overrun done");
  endtask
  task automatic t_shaft;
    @(posedge clk_sys_in);
    shaft <= 1'b0;
    see(7'h00);
    cam_u.sw(0, 1, 1);
    cam_u.sw(0, 0, 1);
    see(7'h00);
    @(posedge clk_sys_in);
    shaft <= 1'b1;
    see(7'h03);
    $display("test shaft done");
  endtask
  task automatic t_lower;
    bus(1'b1, 4'h0, 32'h0000_001E);
    cam_u.sw(1, 0, 1);
    cam_u.sw(1, 1, 1);
    cam_u.sw(0, 1, 1);
    cam_u.sw(1, 1, 1);
    see(7'h58);
    cam_u.rearm(60);
    see(7'h58);
    $display("test lower done");
  endtask
  // restart mid-run with top and lower high, then lower rise with top low
  task automatic t_restart;
    @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    see(7'h01);
    cam_u.sw(1, 0, 1);
    cam_u.sw(1, 1, 1);
    see(7'h01);
    cam_u.sw(0, 0, 1);
    see(7'h03);
    cam_u.sw(1, 0, 1);
    cam_u.sw(1, 1, 1);
    see(7'h05);
    cam_u.sw(0, 0, 1);
    see(7'h03);
    bus(1'b1, 4'h0, 32'h0000_000F);
    cam_u.sw(1, 0, 0);
    see(7'h01);
    cam_u.sw(0, 0, 1);
    see(7'h03);
    cam_u.sw(0, 1, 1);
    see(7'h58);
    $display("test restart done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rstn_in <= 1'b0;
    drv <= 1'b0;
    shaft <= 1'b1;
    addr <= 4'h0;
    wdata <= 32'h0000_0000;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    t_start();
    t_cycle();
    t_seq();
    t_ovr();
    t_shaft();
    t_lower();
    t_restart();
    finish_test();
  end
  initial
  begin
    #100_000;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
